// >>> interconnect_model.sv
`timescale 1ns/100ps
`default_nettype none
module interconnect_model
    import logic_cell_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic step,
    input wire cell_in_t req,
    output var cell_in_t cell_in
);
    logic k;
    // Cell clock toggles only on request, so edges come at uneven spacing
    always_ff @(posedge mclk) k <= rst ? 1'b0 : k ^ step;
    always_comb begin
        cell_in = req;
        cell_in.k = k;
    end
endmodule : interconnect_model
`default_nettype wire

// >>> logic_cell.sv
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_regs.svh"

// Functional notes
// - Two edge-triggered D storage elements share one clock and one enable.
// - Each element picks rising or falling clock edge on its own.
// - A clock inverter is absorbed by flipping that element's edge polarity.
// - Enable is active high; low enable holds the output.
// - An unconnected enable counts as active for that element.
// - No enable inversion inside the cell; outside logic must invert.
// - Either element can be made permanently enabled.
// - Optional latch mode: a rising-edge element is transparent while clock low and holds while high; a falling-edge one does the reverse.
// - Power-up, global init or set/reset high force the configured value.
// - Each element stores a combinational result or a direct input.
// - The forced value is set or reset per element; reset by default.
// - An unconnected set/reset input acts as low.
module logic_cell
    import logic_cell_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Cell clock, enable, set/reset, global init and data from interconnect
    input wire cell_in_t cell_in,
    // Per-element configuration, index 0 feeds xq and index 1 feeds yq
    input wire elem_cfg_t [1:0] elem_cfg,
    // Both elements act as latches instead of flip-flops
    input wire logic latch_mode,
    // Outputs to interconnect
    output cell_out_t cell_out
);

    cell_state_t st;
    cell_state_t next_st;
    elem_ctl_t [1:0] ctl;
    logic [1:0] q;
    logic k_rise;
    logic k_fall;

    // Resolve the configured edge after absorbing any clock inverter
    function automatic logic eff_falling(input elem_cfg_t cfg);
        eff_falling = cfg.falling_edge ^ cfg.clk_invert;
    endfunction : eff_falling

    // One enable pin for both elements, taken as is
    function automatic logic eff_enable(input elem_cfg_t cfg, input logic ec);
        logic en;
        en = ec;
        if (!cfg.ec_used) begin
            en = 1'b1;
        end
        if (cfg.always_enabled) begin
            en = 1'b1;
        end
        eff_enable = en;
    endfunction : eff_enable

    // Value the element is forced to
    function automatic logic force_value(input elem_cfg_t cfg);
        if (cfg.force_set) begin
            force_value = `LC_FORCE_SET_VAL;
        end else begin
            force_value = `LC_FORCE_RESET_VAL;
        end
    endfunction : force_value

    // Global init has top priority, then a connected set/reset
    function automatic logic force_active(input elem_cfg_t cfg, input cell_in_t ci);
        logic f;
        f = 1'b0;
        if (cfg.sr_used && ci.sr) begin
            f = 1'b1;
        end
        if (ci.gfi) begin
            f = 1'b1;
        end
        force_active = f;
    endfunction : force_active

    // Data source for the element
    function automatic logic select_data(
        input elem_cfg_t cfg,
        input cell_in_t ci,
        input logic direct
    );
        case (cfg.src_sel)
            SRC_F: select_data = ci.f;
            SRC_G: select_data = ci.g;
            SRC_H: select_data = ci.h;
            SRC_DIRECT: select_data = direct;
            default: select_data = ci.f;
        endcase
    endfunction : select_data

    // Edges of the shared cell clock, seen against the last sampled level.
    // The cell clock is user logic on mclk, so it is read unsynchronised.
    assign k_rise = cell_in.k && !st.k_prev;
    assign k_fall = !cell_in.k && st.k_prev;

    // Decode per element control from the shared pins
    always_comb begin
        for (int i = 0; i < `LC_ELEMENTS; i++) begin
            ctl[i].latch = latch_mode;
            if (eff_falling(elem_cfg[i])) begin
                ctl[i].active_edge = k_fall;
                // An inverted latch opens while the clock is high
                ctl[i].transparent = cell_in.k;
            end else begin
                ctl[i].active_edge = k_rise;
                ctl[i].transparent = !cell_in.k;
            end
            ctl[i].enable = eff_enable(elem_cfg[i], cell_in.ec);
            ctl[i].force_now = force_active(elem_cfg[i], cell_in);
            ctl[i].force_val = force_value(elem_cfg[i]);
            ctl[i].d = select_data(elem_cfg[i], cell_in, cell_in.direct[i]);
        end
    end

    // Both elements are the same circuit with their own configuration
    storage_element u_elem_x (
        .mclk(mclk),
        .rst(rst),
        .ctl(ctl[0]),
        .q(q[0])
    );

    storage_element u_elem_y (
        .mclk(mclk),
        .rst(rst),
        .ctl(ctl[1]),
        .q(q[1])
    );

    // Combinational results also leave the cell, one flop later so that
    // every output is registered; they line up in time with xq and yq.
    always_comb begin
        next_st = st;
        next_st.k_prev = cell_in.k;
        next_st.x = cell_in.f;
        next_st.y = cell_in.g;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{k_prev: `LC_K_RST, x: `LC_COMB_RST, y: `LC_COMB_RST};
        end else begin
            st <= next_st;
        end
    end

    assign cell_out.x = st.x;
    assign cell_out.y = st.y;
    assign cell_out.xq = q[0];
    assign cell_out.yq = q[1];

endmodule : logic_cell
`default_nettype wire

// >>> logic_cell_pkg.sv
package logic_cell_pkg;

    // Which signal an element stores
    typedef enum logic [1:0] {
        SRC_F = 2'h0,
        SRC_G = 2'h1,
        SRC_H = 2'h3,
        SRC_DIRECT = 2'h2
    } src_sel_t;

    // Power-up sequence of one element
    typedef enum logic {
        ST_INIT = 1'b0,
        ST_RUN = 1'b1
    } init_state_t;

    // Per-element configuration; all zero is the plain default element
    typedef struct packed {
        logic falling_edge;
        logic clk_invert;
        logic ec_used;
        logic always_enabled;
        logic force_set;
        logic sr_used;
        src_sel_t src_sel;
    } elem_cfg_t;

    // Signals arriving from the interconnect
    typedef struct packed {
        logic k;
        logic ec;
        logic sr;
        logic gfi;
        logic f;
        logic g;
        logic h;
        logic [1:0] direct;
    } cell_in_t;

    // Decoded control for one storage element
    typedef struct packed {
        logic latch;
        logic active_edge;
        logic transparent;
        logic enable;
        logic force_now;
        logic force_val;
        logic d;
    } elem_ctl_t;

    // Signals driven back onto the interconnect
    typedef struct packed {
        logic x;
        logic y;
        logic xq;
        logic yq;
    } cell_out_t;

    // State of one storage element
    typedef struct packed {
        init_state_t phase;
        logic q;
    } elem_state_t;

    // State of the cell around its elements
    typedef struct packed {
        logic k_prev;
        logic x;
        logic y;
    } cell_state_t;

endpackage : logic_cell_pkg

// >>> logic_cell_props.sv
`timescale 1ns/100ps
`default_nettype none
module logic_cell_props
    import logic_cell_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire cell_in_t cell_in,
    input wire elem_cfg_t [1:0] elem_cfg,
    input wire logic latch_mode,
    input wire cell_out_t cell_out
);
    elem_cfg_t a, b;
    cell_in_t i;
    cell_out_t o;
    logic [1:0] up;
    logic fa, fb, ea, eb, ha, hb;
    always_comb begin
        a = elem_cfg[0];
        b = elem_cfg[1];
        i = cell_in;
        o = cell_out;
        fa = a.falling_edge ^ a.clk_invert;
        fb = b.falling_edge ^ b.clk_invert;
        ea = i.ec | !a.ec_used | a.always_enabled;
        eb = i.ec | !b.ec_used | b.always_enabled;
        ha = i.gfi | (i.sr & a.sr_used);
        hb = i.gfi | (i.sr & b.sr_used);
    end
    // First edge after release is the power-up load, not a capture
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) up <= 2'h0;
        else if (!up[1]) up <= up + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_up;
        up == 2'h1 |-> o.xq == $past(a.force_set);
    endproperty
    a_up: assert property (p_up) else $error("power-up value");
    property p_frc;
        |up && ha |=> o.xq == $past(a.force_set);
    endproperty
    a_frc: assert property (p_frc) else $error("forced value");
    property p_gfi;
        |up && i.gfi |=> o.yq == $past(b.force_set);
    endproperty
    a_gfi: assert property (p_gfi) else $error("global init");
    property p_hold;
        |up && !ha && !ea |=> $stable(o.xq);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rise;
        |up && !latch_mode && !ha && ea && !fa && !$past(i.k) && i.k
            && a.src_sel == SRC_DIRECT |=> o.xq == $past(i.direct[0]);
    endproperty
    a_rise: assert property (p_rise) else $error("rise capture");
    property p_fall;
        |up && !latch_mode && !hb && eb && fb && $past(i.k) && !i.k
            && b.src_sel == SRC_G |=> o.yq == $past(i.g);
    endproperty
    a_fall: assert property (p_fall) else $error("fall capture");
    property p_lat;
        |up && latch_mode && !ha && ea && i.k == fa
            && a.src_sel == SRC_DIRECT |=> o.xq == $past(i.direct[0]);
    endproperty
    a_lat: assert property (p_lat) else $error("latch open");
    property p_comb;
        |up |=> o.x == $past(i.f) && o.y == $past(i.g);
    endproperty
    a_comb: assert property (p_comb) else $error("comb out");
endmodule : logic_cell_props
`default_nettype wire

// >>> logic_cell_regs.svh
`ifndef LOGIC_CELL_REGS_SVH
`define LOGIC_CELL_REGS_SVH

// Value forced when the element is configured for reset (the default)
`define LC_FORCE_RESET_VAL 1'b0
// Value forced when the element is configured for set
`define LC_FORCE_SET_VAL 1'b1
// Flip-flop contents while rst is asserted
`define LC_Q_RST 1'b0
// Last seen cell clock level while rst is asserted
`define LC_K_RST 1'b0
// Registered combinational outputs while rst is asserted
`define LC_COMB_RST 1'b0
// Number of storage elements in one cell
`define LC_ELEMENTS 2

`endif

// >>> storage_element.sv
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_regs.svh"

module storage_element
    import logic_cell_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Decoded control from the cell
    input wire elem_ctl_t ctl,
    // Stored value
    output logic q
);

    elem_state_t st;
    elem_state_t next_st;

    always_comb begin
        next_st = st;
        if (st.phase == ST_INIT) begin
            // Power-up loads the configured value before anything else
            next_st.q = ctl.force_val;
            next_st.phase = ST_RUN;
        end else if (ctl.force_now) begin
            next_st.q = ctl.force_val;
        end else if (ctl.latch) begin
            if (ctl.transparent && ctl.enable) begin
                next_st.q = ctl.d;
            end
        end else if (ctl.active_edge && ctl.enable) begin
            next_st.q = ctl.d;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{phase: ST_INIT, q: `LC_Q_RST};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule : storage_element
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import logic_cell_pkg::*;
    logic mclk, rst, step, lm, pwr, kp, fall, en, d;
    logic [1:0] mq;
    logic [15:0] lf;
    elem_cfg_t [1:0] cfg;
    elem_cfg_t c;
    cell_in_t req, ci;
    cell_out_t co, e;
    cell_out_t exp_q[$];
    int fail_count, cmp_count, n, i;
    interconnect_model link (.mclk(mclk), .rst(rst), .step(step), .req(req), .cell_in(ci));
    logic_cell dut (.mclk(mclk), .rst(rst), .cell_in(ci), .elem_cfg(cfg),
        .latch_mode(lm), .cell_out(co));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input cell_out_t seen, input cell_out_t want);
        cmp_count++;
        if (seen !== want) begin
            fail_count++;
            $display("FAIL cell_out exp %h seen %h", want, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        end_sim();
    end
    // Expected outputs, one edge after the inputs that cause them
    always @(posedge mclk) begin
        if (rst) begin
            mq = 2'h0;
            pwr = 1'b1;
            kp = 1'b0;
        end else begin
            for (i = 0; i < 2; i++) begin
                c = cfg[i];
                fall = c.falling_edge ^ c.clk_invert;
                en = ci.ec | !c.ec_used | c.always_enabled;
                case (c.src_sel)
                    SRC_F: d = ci.f;
                    SRC_G: d = ci.g;
                    SRC_H: d = ci.h;
                    default: d = ci.direct[i];
                endcase
                if (pwr | ci.gfi | (ci.sr & c.sr_used)) mq[i] = c.force_set;
                else if (en && (lm ? ci.k == fall : ci.k != kp && ci.k != fall)) mq[i] = d;
            end
            pwr = 1'b0;
            kp = ci.k;
        end
        exp_q.push_back({ci.f & !rst, ci.g & !rst, mq[0], mq[1]});
    end
    always @(negedge mclk) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (rst) e = '0;
            check(co, e);
        end
    end
    initial begin
        rst = 1'b1;
        step = 1'b0;
        lm = 1'b0;
        req = '0;
        cfg = '0;
        lf = 16'h0046;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            lf = lfsr(lf);
            step <= lf[0];
            // Sparse force strobes so that normal capture dominates
            req <= {1'b0, lf[1], &lf[4:2], &lf[8:5], lf[11:9], lf[13:12]};
            if (n % 64 == 0) begin
                cfg <= lfsr(lf ^ 16'h5a5a);
                lm <= lf[14];
            end
            rst <= (n >= 1500 && n < 1505);
        end
        end_sim();
    end
endmodule : testbench
bind logic_cell logic_cell_props chk (.mclk(mclk), .rst(rst), .cell_in(cell_in),
    .elem_cfg(elem_cfg), .latch_mode(latch_mode), .cell_out(cell_out));
`default_nettype wire
